// *** logic/tmc_timer16.sv ***
// 16-bit timer core: mode decode, clock select, capture, compare, byte latch
// Notes on behaviour
// RL1: four mode bits from both controls; 13 reserved
// RL2: mode 0 counts to 0xFFFF, immediate, overflow at max
// RL3: modes 4,12 clear at compare A or capture
// RL4: phase correct: fixed or register top, bottom overflow
// RL5: fast modes: top update, overflow at top
// RL6: modes 8,9 update and overflow at bottom
// RL7: filter needs four equal samples before change
// RL8: edge select: zero falling, one rising
// RL9: capture copies count and sets capture flag
// RL10: capture off when capture register is top
// RL11: software writes zero to reserved control bit
// RL12: clock select stop, direct, prescaled divides
// RL13: codes 110/111 count external falling/rising edges
// RL14: external pin counts even when driven locally
// RL15: sixteen-bit access through one shared high latch
// RL16: count write blocks next tick's compare matches
// RL17: both compare registers compared with count continuously
// RL18: compare flag sets on tick after equality
// RL19: flags clear on vector or written one
// RL20: software never selects reserved mode
module tmc_timer16 (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic [3:0] vecAck,
  input wire logic capturePin,
  input wire logic extCountPin,
  output logic overflowFlag,
  output logic compareAFlag,
  output logic compareBFlag,
  output logic captureFlag,
  output logic compareAMatch,
  output logic compareBMatch
);
  import tmc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [15:0] count;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] cmpABuf;
    logic [15:0] cmpBBuf;
    logic [15:0] capt;
    logic [7:0] temp;
    logic [7:0] flags;
    logic [9:0] presc;
    logic countDown;
    logic blockMatch;
    logic [1:0] capSync;
    logic [1:0] extSync;
    logic extPrev;
    logic [FILTER_SAMPLES-2:0] capHist;
    logic capLevel;
    logic [7:0] rdData;
    logic matchA;
    logic matchB;
  } tmc_state_t;

  tmc_state_t q;
  tmc_state_t d;

  logic [3:0] waveMode;
  tmc_family_t family;
  tmc_top_src_t topSrc;
  logic [15:0] fixedTop;
  logic [15:0] topValue;
  logic [2:0] clkSourceSel;
  logic tick;
  logic atTop;
  logic atBottom;
  logic updateBuf;
  logic setOvf;
  logic captureOn;
  logic capRaw;
  logic capNext;
  logic capEdge;
  logic extRise;
  logic extFall;
  logic [7:0] flagSet;
  logic [7:0] flagClr;

  // ****************************************
  // mode decode
  // ****************************************
  // mode formed from two bits of each control register
  assign waveMode = {q.ctrlB[POS_WAVE_HI+1:POS_WAVE_HI], q.ctrlA[1:0]}; // RL1
  assign clkSourceSel = q.ctrlB[POS_CLK_SEL+2:POS_CLK_SEL];

  // family, top source and fixed top for every code
  always_comb begin
    family = TMC_NORMAL;
    topSrc = TMC_TOP_FIXED;
    fixedTop = TOP_MAX; // RL2
    unique case (waveMode)
      4'h0: family = TMC_NORMAL; // RL2
      4'h1, 4'h2, 4'h3: family = TMC_PHASE; // RL4
      4'h4: begin
        family = TMC_CLEAR_ON_MATCH; // RL3
        topSrc = TMC_TOP_CMPA;
      end
      4'h5, 4'h6, 4'h7: family = TMC_FAST; // RL5
      4'h8: begin
        family = TMC_PHASE_FREQ; // RL6
        topSrc = TMC_TOP_CAPT;
      end
      4'h9: begin
        family = TMC_PHASE_FREQ; // RL6
        topSrc = TMC_TOP_CMPA;
      end
      4'hA: begin
        family = TMC_PHASE; // RL4
        topSrc = TMC_TOP_CAPT;
      end
      4'hB: begin
        family = TMC_PHASE; // RL4
        topSrc = TMC_TOP_CMPA;
      end
      4'hC: begin
        family = TMC_CLEAR_ON_MATCH; // RL3
        topSrc = TMC_TOP_CAPT;
      end
      // reserved code just runs as normal; software must avoid it
      4'hD: family = TMC_NORMAL; // RL20
      4'hE: begin
        family = TMC_FAST; // RL5
        topSrc = TMC_TOP_CAPT;
      end
      4'hF: begin
        family = TMC_FAST; // RL5
        topSrc = TMC_TOP_CMPA;
      end
    endcase
    // low two bits pick the 8, 9 or 10 bit fixed top
    if (waveMode[3] == 1'b0 && waveMode[1:0] != 2'b00) begin
      unique case (waveMode[1:0])
        2'b01: fixedTop = TOP_8BIT; // RL4
        2'b10: fixedTop = TOP_9BIT; // RL4
        default: fixedTop = TOP_10BIT; // RL4
      endcase
    end
  end

  // top value from the selected source
  always_comb begin
    unique case (topSrc)
      TMC_TOP_CMPA: topValue = q.cmpA; // RL3
      TMC_TOP_CAPT: topValue = q.capt; // RL3
      default: topValue = fixedTop;
    endcase
  end

  // ****************************************
  // clock select
  // ****************************************
  // pin is sampled regardless of its port direction
  assign extRise = q.extSync[1] & ~q.extPrev; // RL14
  assign extFall = ~q.extSync[1] & q.extPrev; // RL14

  // one-cycle count enable from the prescaler or the pin
  always_comb begin
    unique case (clkSourceSel)
      3'b000: tick = 1'b0; // RL12
      3'b001: tick = 1'b1; // RL12
      3'b010: tick = &(q.presc | ~DIV8_MASK); // RL12
      3'b011: tick = &(q.presc | ~DIV64_MASK); // RL12
      3'b100: tick = &(q.presc | ~DIV256_MASK); // RL12
      3'b101: tick = &(q.presc | ~DIV1024_MASK); // RL12
      3'b110: tick = extFall; // RL13
      3'b111: tick = extRise; // RL13
    endcase
  end

  assign atTop = (q.count == topValue);
  assign atBottom = (q.count == RST_WORD);

  // ****************************************
  // capture path
  // ****************************************
  // capture register used as top disconnects the pin
  assign captureOn = (topSrc != TMC_TOP_CAPT); // RL10
  assign capRaw = q.capSync[1];

  // filter only moves after a run of equal samples
  always_comb begin
    capNext = capRaw;
    if (q.ctrlB[POS_FILTER_EN]) begin
      capNext = q.capLevel;
      if (&{q.capHist, capRaw} || ~|{q.capHist, capRaw}) begin
        capNext = capRaw; // RL7
      end
    end
  end

  // edge select picks polarity of the filtered level
  assign capEdge = (capNext != q.capLevel) &&
    (capNext == q.ctrlB[POS_EDGE_SEL]); // RL8

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    flagSet = 8'h00;
    flagClr = 8'h00;
    updateBuf = 1'b0;
    setOvf = 1'b0;
    d.presc = q.presc + 10'h001;
    d.capSync = {q.capSync[0], capturePin};
    d.extSync = {q.extSync[0], extCountPin};
    d.extPrev = q.extSync[1];
    d.capHist = {q.capHist[FILTER_SAMPLES-3:0], capRaw};
    d.capLevel = capNext;
    d.matchA = 1'b0;
    d.matchB = 1'b0;

    // counting sequence per family
    if (tick) begin
      d.blockMatch = 1'b0;
      unique case (family)
        TMC_NORMAL, TMC_CLEAR_ON_MATCH: begin
          d.count = atTop ? RST_WORD : q.count + 16'h0001; // RL3
          setOvf = (q.count == TOP_MAX); // RL2
          if (family == TMC_CLEAR_ON_MATCH && topSrc == TMC_TOP_CAPT &&
              atTop) begin
            flagSet[POS_FLAG_CAPT] = 1'b1;
          end
        end
        TMC_FAST: begin
          d.count = atTop ? RST_WORD : q.count + 16'h0001;
          setOvf = atTop; // RL5
          updateBuf = atTop; // RL5
          if (topSrc == TMC_TOP_CAPT && atTop) begin
            flagSet[POS_FLAG_CAPT] = 1'b1;
          end
        end
        default: begin
          // dual slope: turn round at top and at bottom
          if (!q.countDown && atTop) begin
            d.countDown = 1'b1;
            d.count = q.count - 16'h0001;
          end else if (q.countDown && atBottom) begin
            d.countDown = 1'b0;
            d.count = q.count + 16'h0001;
          end else if (q.countDown) begin
            d.count = q.count - 16'h0001;
          end else begin
            d.count = q.count + 16'h0001;
          end
          setOvf = q.countDown && atBottom; // RL4 RL6
          if (family == TMC_PHASE) begin
            updateBuf = !q.countDown && atTop; // RL4
          end else begin
            updateBuf = q.countDown && atBottom; // RL6
          end
          if (topSrc == TMC_TOP_CAPT && !q.countDown && atTop) begin
            flagSet[POS_FLAG_CAPT] = 1'b1;
          end
        end
      endcase
      // equality seen during the previous timer cycle raises the flag
      if (!q.blockMatch && q.count == q.cmpA) begin
        flagSet[POS_FLAG_CMPA] = 1'b1; // RL17 RL18
        d.matchA = 1'b1;
      end
      if (!q.blockMatch && q.count == q.cmpB) begin
        flagSet[POS_FLAG_CMPB] = 1'b1; // RL17 RL18
        d.matchB = 1'b1;
      end
    end
    flagSet[POS_FLAG_OVF] = setOvf;

    // double-buffered compare values load at the update point
    if (updateBuf) begin
      d.cmpA = q.cmpABuf; // RL4 RL5 RL6
      d.cmpB = q.cmpBBuf;
    end

    // capture takes the count as it stands
    if (captureOn && capEdge) begin
      d.capt = q.count; // RL9
      flagSet[POS_FLAG_CAPT] = 1'b1; // RL9
    end

    // vector acknowledge clears the matching flag
    flagClr[POS_FLAG_OVF] = vecAck[0]; // RL19
    flagClr[POS_FLAG_CMPA] = vecAck[1]; // RL19
    flagClr[POS_FLAG_CMPB] = vecAck[2]; // RL19
    flagClr[POS_FLAG_CAPT] = vecAck[3]; // RL19

    // register writes; low byte commits the latched high byte
    if (ioWrEn) begin
      unique case (ioAddr)
        OFS_CTRL_A: d.ctrlA = ioWrData;
        OFS_CTRL_B: d.ctrlB = ioWrData;
        OFS_COUNT_HIGH, OFS_CMP_A_HIGH, OFS_CMP_B_HIGH,
        OFS_CAPT_HIGH: d.temp = ioWrData; // RL15
        OFS_COUNT_LOW: begin
          d.count = {q.temp, ioWrData}; // RL15
          d.blockMatch = 1'b1; // RL16
        end
        OFS_CMP_A_LOW: begin
          d.cmpABuf = {q.temp, ioWrData}; // RL15
          if (family == TMC_NORMAL || family == TMC_CLEAR_ON_MATCH) begin
            d.cmpA = {q.temp, ioWrData}; // RL2 RL3
          end
        end
        OFS_CMP_B_LOW: begin
          d.cmpBBuf = {q.temp, ioWrData}; // RL15
          if (family == TMC_NORMAL || family == TMC_CLEAR_ON_MATCH) begin
            d.cmpB = {q.temp, ioWrData}; // RL2 RL3
          end
        end
        OFS_CAPT_LOW: d.capt = {q.temp, ioWrData}; // RL15
        OFS_FLAGS: flagClr = flagClr | ioWrData; // RL19
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    d.flags = ((q.flags & ~flagClr) | flagSet) &
      {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 3'b000};

    // reads: count and capture low byte reads park the high byte in the latch
    d.rdData = 8'h00;
    if (ioRdEn) begin
      unique case (ioAddr)
        // force strobes read zero, reserved bit reads zero
        OFS_CTRL_A: d.rdData = {q.ctrlA[7:POS_FORCE_LO+2], 2'b00,
          q.ctrlA[1:0]};
        OFS_CTRL_B: d.rdData = q.ctrlB & ~(8'h01 << POS_RESERVED_B); // RL11
        OFS_COUNT_LOW: begin
          d.rdData = q.count[7:0]; // RL15
          d.temp = q.count[15:8];
        end
        OFS_CAPT_LOW: begin
          d.rdData = q.capt[7:0]; // RL15
          d.temp = q.capt[15:8];
        end
        OFS_CMP_A_LOW: d.rdData = q.cmpABuf[7:0];
        OFS_CMP_A_HIGH: d.rdData = q.cmpABuf[15:8];
        OFS_CMP_B_LOW: d.rdData = q.cmpBBuf[7:0];
        OFS_CMP_B_HIGH: d.rdData = q.cmpBBuf[15:8];
        OFS_COUNT_HIGH, OFS_CAPT_HIGH: d.rdData = q.temp; // RL15
        OFS_FLAGS: d.rdData = q.flags;
        default: d.rdData = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // whole state held in one register bank
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flip-flops
  assign ioRdData = q.rdData;
  assign overflowFlag = q.flags[POS_FLAG_OVF];
  assign compareAFlag = q.flags[POS_FLAG_CMPA];
  assign compareBFlag = q.flags[POS_FLAG_CMPB];
  assign captureFlag = q.flags[POS_FLAG_CAPT];
  assign compareAMatch = q.matchA;
  assign compareBMatch = q.matchB;

endmodule : tmc_timer16

// *** logic/tmc_pkg.sv ***
// package: register offsets, field positions and timing counts for the timer
package tmc_pkg;

  // ****************************************
  // register offsets on the i/o port
  // ****************************************
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_COUNT_LOW = 4'h2;
  localparam logic [3:0] OFS_COUNT_HIGH = 4'h3;
  localparam logic [3:0] OFS_CMP_A_LOW = 4'h4;
  localparam logic [3:0] OFS_CMP_A_HIGH = 4'h5;
  localparam logic [3:0] OFS_CMP_B_LOW = 4'h6;
  localparam logic [3:0] OFS_CMP_B_HIGH = 4'h7;
  localparam logic [3:0] OFS_CAPT_LOW = 4'h8;
  localparam logic [3:0] OFS_CAPT_HIGH = 4'h9;
  localparam logic [3:0] OFS_FLAGS = 4'hA;

  // ****************************************
  // field positions
  // ****************************************
  localparam int POS_FILTER_EN = 7;
  localparam int POS_EDGE_SEL = 6;
  localparam int POS_RESERVED_B = 5;
  localparam int POS_WAVE_HI = 3;
  localparam int POS_CLK_SEL = 0;
  localparam int POS_FORCE_LO = 2;
  localparam int POS_FLAG_OVF = 7;
  localparam int POS_FLAG_CMPA = 6;
  localparam int POS_FLAG_CMPB = 5;
  localparam int POS_FLAG_CAPT = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************
  // counting limits and prescaler taps
  // ****************************************
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;
  localparam int FILTER_SAMPLES = 4;

  // waveform families
  typedef enum logic [2:0] {
    TMC_NORMAL,
    TMC_CLEAR_ON_MATCH,
    TMC_PHASE,
    TMC_PHASE_FREQ,
    TMC_FAST
  } tmc_family_t;

  // where the top value comes from
  typedef enum logic [1:0] {
    TMC_TOP_FIXED,
    TMC_TOP_CMPA,
    TMC_TOP_CAPT
  } tmc_top_src_t;

endpackage : tmc_pkg

// *** tb/tmc_timer16_monitor.sv ***
// checker of the timer core's port relations
module tmc_timer16_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] ioAddr,
  input wire logic ioWrEn,
  input wire logic ioRdEn,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic [3:0] vecAck,
  input wire logic capturePin,
  input wire logic extCountPin,
  input wire logic overflowFlag,
  input wire logic compareAFlag,
  input wire logic compareBFlag,
  input wire logic captureFlag,
  input wire logic compareAMatch,
  input wire logic compareBMatch
);
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  logic wrFlags;

  // ****************************************
  // helper decode and assertions
  // ****************************************
  // a flag write with a one in a bit clears that flag
  assign wrFlags = ioWrEn && ioAddr == OFS_FLAGS;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_rd_quiet: assert property (!ioRdEn |=> ioRdData == 8'h00)
    else $error("read data not zero outside a read");
  a_cmpa_cause: assert property ($rose(compareAFlag) |-> compareAMatch)
    else $error("compare A flag set without match pulse");
  a_cmpb_cause: assert property ($rose(compareBFlag) |-> compareBMatch)
    else $error("compare B flag set without match pulse");
  a_match_flag: assert property (compareAMatch |-> compareAFlag)
    else $error("compare A match without flag");
  a_ovf_hold: assert property (overflowFlag && !vecAck[0] &&
    !(wrFlags && ioWrData[POS_FLAG_OVF]) |=> overflowFlag)
    else $error("overflow flag dropped without clear");
  a_capt_hold: assert property (captureFlag && !vecAck[3] &&
    !(wrFlags && ioWrData[POS_FLAG_CAPT]) |=> captureFlag)
    else $error("capture flag dropped without clear");
  a_cmpa_ack: assert property (vecAck[1] |=>
    !compareAFlag || compareAMatch)
    else $error("compare A flag kept after vector");
  a_cmpb_wclr: assert property (wrFlags && ioWrData[POS_FLAG_CMPB] |=>
    !compareBFlag || compareBMatch)
    else $error("compare B flag kept after write one");
  a_wr_block: assert property (ioWrEn && ioAddr == OFS_COUNT_LOW |->
    ##2 !compareAMatch && !compareBMatch)
    else $error("match on tick after count write");

  c_match: cover property (compareAMatch);
  c_capt: cover property ($rose(captureFlag));
  c_ovf: cover property ($rose(overflowFlag));
endmodule : tmc_timer16_monitor

bind tmc_timer16 tmc_timer16_monitor u_mon (
  .clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
  .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData),
  .vecAck(vecAck), .capturePin(capturePin), .extCountPin(extCountPin),
  .overflowFlag(overflowFlag), .compareAFlag(compareAFlag),
  .compareBFlag(compareBFlag), .captureFlag(captureFlag),
  .compareAMatch(compareAMatch), .compareBMatch(compareBMatch)
);

// *** tb/tmc_pin_model.sv ***
// far-side driver of the capture and external count pins
module tmc_pin_model (
  input wire logic clk,
  output logic capPin,
  output logic extPin
);
  timeunit 1ns;
  timeprecision 1ns;

  // pins idle at fixed levels; both are plain push-pull lines
  initial begin
    capPin = 1'b1;
    extPin = 1'b0;
  end

  // move the capture pin, then hold it for some clocks
  task automatic setCap(input logic v, input int hold);
    @(posedge clk);
    #1 capPin = v;
    repeat (hold) @(posedge clk);
    #1;
  endtask : setCap

  // toggles spaced wide enough to pass the two-flop synchroniser
  task automatic extToggles(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 extPin = !extPin;
      repeat (3) @(posedge clk);
    end
    #1;
  endtask : extToggles
endmodule : tmc_pin_model

// *** tb/tb.sv ***
// self-checking bench for the 16-bit timer core
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tmc_pkg::*;
  logic clk = 1'b0;
  logic arst_n, ioWrEn, ioRdEn, capPin, extPin, ovf, fA, fB, fC, mA, mB;
  logic [3:0] ioAddr, vecAck;
  logic [7:0] ioWrData, ioRdData, rdv;
  logic [15:0] w;
  int miscompares, compares;
  logic [3:0] modeTab [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h6, 4'h7, 4'h9, 4'hB, 4'hF};
  logic [15:0] topTab [11] = '{TOP_MAX, TOP_8BIT, TOP_9BIT, TOP_10BIT,
    16'h0100, TOP_8BIT, TOP_9BIT, TOP_10BIT, 16'h0100, 16'h0100, 16'h0100};
  logic [10:0] ovfExp = 11'h4E1;
  int divs [6] = '{0, 1, 8, 64, 256, 1024};

  always #20 clk = ~clk;

  tmc_timer16 u_dut (
    .clk(clk), .arst_n(arst_n), .ioAddr(ioAddr), .ioWrEn(ioWrEn),
    .ioRdEn(ioRdEn), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .vecAck(vecAck), .capturePin(capPin), .extCountPin(extPin),
    .overflowFlag(ovf), .compareAFlag(fA), .compareBFlag(fB),
    .captureFlag(fC), .compareAMatch(mA), .compareBMatch(mB)
  );

  tmc_pin_model u_pin (.clk(clk), .capPin(capPin), .extPin(extPin));

  // ****************************************
  // access and checking tasks
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
    input string what);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // strobes rest one cycle so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWrData = d;
    ioWrEn = 1'b1;
    @(posedge clk);
    #1 ioWrEn = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    ioAddr = a;
    ioRdEn = 1'b1;
    @(posedge clk);
    #1 ioRdEn = 1'b0;
    v = ioRdData;
    @(posedge clk);
    #1;
  endtask : rd

  // high byte goes to the shared latch, low byte commits
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask : rd16

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  // watchdog sized well above the expected run
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    test_done();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {arst_n, ioWrEn, ioRdEn, ioAddr, ioWrData, vecAck} = '0;
    miscompares = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    tick(1);
    // unmapped writes must vanish; every place reads zero after reset
    for (int a = 11; a < 16; a++) wr(a[3:0], 8'hFF);
    for (int a = 0; a < 16; a++) begin
      rd(a[3:0], rdv);
      chk(16'(rdv), 16'h0000, "reset value");
    end
    wr16(OFS_COUNT_LOW, 16'h1234);
    wr16(OFS_CMP_A_LOW, 16'hA55A);
    wr(OFS_COUNT_HIGH, 8'h77);
    wr(OFS_CMP_B_LOW, 8'h11);
    rd16(OFS_COUNT_LOW, w);
    chk(w, 16'h1234, "count");
    rd16(OFS_CMP_A_LOW, w);
    chk(w, 16'hA55A, "compare A");
    rd16(OFS_CMP_B_LOW, w);
    chk(w, 16'h7711, "compare B");
    // overflow moment per mode: near top, only top or max modes flag
    wr16(OFS_CMP_A_LOW, 16'h0100);
    for (int i = 0; i < 11; i++) begin
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_CTRL_A, {6'h00, modeTab[i][1:0]});
      wr16(OFS_COUNT_LOW, topTab[i] - 16'h0008);
      wr(OFS_FLAGS, 8'hFF);
      wr(OFS_CTRL_B, {3'h0, modeTab[i][3:2], 3'h1});
      tick(30);
      rd(OFS_FLAGS, rdv);
      chk(16'(rdv[POS_FLAG_OVF]), 16'(ovfExp[i]), "ovf");
      chk(16'(ovf), 16'(ovfExp[i]), "ovf pin");
    end
    // clock sources: eight timer ticks give a count near eight
    wr(OFS_CTRL_A, 8'h00);
    for (int s = 0; s < 6; s++) begin
      wr(OFS_CTRL_B, 8'h00);
      wr16(OFS_COUNT_LOW, 16'h0000);
      wr(OFS_CTRL_B, s[7:0]);
      tick(8 * divs[s]);
      wr(OFS_CTRL_B, 8'h00);
      rd16(OFS_COUNT_LOW, w);
      chk(16'((s == 0) ? (w === 16'h0000) : (w >= 7 && w <= 11)), 16'h0001,
        "prescale");
    end
    // pin starts low: five toggles give two falls and three rises
    for (int e = 0; e < 2; e++) begin
      wr16(OFS_COUNT_LOW, 16'h0000);
      wr(OFS_CTRL_B, 8'h06 + e[7:0]);
      u_pin.extToggles(5);
      tick(6);
      wr(OFS_CTRL_B, 8'h00);
      u_pin.extToggles(1);
      rd16(OFS_COUNT_LOW, w);
      chk(w, e ? 16'h0003 : 16'h0002, "ext count");
    end
    // capture with the timer stopped so the copied count is exact
    for (int k = 0; k < 4; k++) begin
      u_pin.setCap(k[0], 8);
      wr(OFS_CTRL_B, {k[1], k[0], 6'h00});
      wr16(OFS_COUNT_LOW, 16'h0AB0 + 16'(k));
      vecAck = 4'h8;
      tick(1);
      vecAck = 4'h0;
      u_pin.setCap(!k[0], 10);
      chk(16'(fC), 16'h0000, "wrong edge");
      // three samples only: filter needs four, so it rejects this when on; with the filter off it is captured
      u_pin.setCap(k[0], 2);
      u_pin.setCap(!k[0], 10);
      chk(16'(fC), 16'(!k[1]), "short pulse");
      u_pin.setCap(k[0], 12);
      chk(16'(fC), 16'h0001, "capture flag");
      rd16(OFS_CAPT_LOW, w);
      chk(w, 16'h0AB0 + 16'(k), "capture value");
    end
    // capture register as top: pin edges are ignored
    wr(OFS_CTRL_B, 8'h58);
    wr(OFS_FLAGS, 8'h08);
    u_pin.setCap(1'b0, 10);
    u_pin.setCap(1'b1, 10);
    chk(16'(fC), 16'h0000, "capture off");
    rd16(OFS_CAPT_LOW, w);
    chk(w, 16'h0AB3, "capture kept");
    // counting to the capture top wraps there and raises the capture flag
    wr16(OFS_COUNT_LOW, 16'h0AB0);
    wr(OFS_CTRL_B, 8'h59);
    tick(8);
    wr(OFS_CTRL_B, 8'h58);
    chk(16'(fC), 16'h0001, "capture at top");
    rd16(OFS_COUNT_LOW, w);
    chk(w, 16'h0006, "wrap at top");
    // both channels match while counting, then vector clears them
    wr(OFS_CTRL_B, 8'h00);
    wr16(OFS_CMP_A_LOW, 16'h0005);
    wr16(OFS_CMP_B_LOW, 16'h0007);
    wr16(OFS_COUNT_LOW, 16'h0000);
    wr(OFS_FLAGS, 8'hFF);
    wr(OFS_CTRL_B, 8'h01);
    tick(5);
    // count 5 meets compare A on this tick; B is still two ticks away
    chk(16'({mA, mB}), 16'h0002, "match pulse");
    tick(7);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, rdv);
    chk(16'(rdv), 16'h0060, "compare flags");
    chk(16'({ovf, fA, fB, fC}), 16'h0006, "flag pins");
    vecAck = 4'h6;
    tick(1);
    vecAck = 4'h0;
    rd(OFS_FLAGS, rdv);
    chk(16'(rdv), 16'h0000, "vector clear");
    // writing the match value itself must not raise the flag
    wr16(OFS_CMP_A_LOW, 16'h0040);
    wr16(OFS_COUNT_LOW, 16'h0030);
    wr(OFS_CTRL_B, 8'h01);
    tick(4);
    wr16(OFS_COUNT_LOW, 16'h0040);
    tick(10);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, rdv);
    chk(16'(rdv[POS_FLAG_CMPA]), 16'h0000, "blocked match");
    test_done();
  end
endmodule : tb
